/* File: shared/mfd_pkg.sv */
// constants and types for the microword function and store decoder
package mfd_pkg;
	// microword layout
	localparam int MW_W     = 24;
	localparam int DATA_W   = 16;
	localparam int CSAR_W   = 10;
	localparam int FN_LSB   = 12;
	localparam int ST_LSB   = 8;
	localparam int SP_LSB   = 4;
	localparam int TGT_B8   = 17;
	localparam int TGT_B9   = 12;
	localparam int DIV_STEPS_DEF = 16;

	// function field codes
	localparam logic [4:0] FN_ROT_FLAG_IDX  = 5'h00;
	localparam logic [4:0] FN_ROT_FLAG_EXT  = 5'h01;
	localparam logic [4:0] FN_PHASE_1A      = 5'h02;
	localparam logic [4:0] FN_MULT_STEP     = 5'h03;
	localparam logic [4:0] FN_DIV_STEP      = 5'h04;
	localparam logic [4:0] FN_SUB           = 5'h05;
	localparam logic [4:0] FN_ADD_ONE_OVF   = 5'h08;
	localparam logic [4:0] FN_INC           = 5'h09;
	localparam logic [4:0] FN_NOR           = 5'h0d;
	localparam logic [4:0] FN_XOR           = 5'h0e;
	localparam logic [4:0] FN_CALL0         = 5'h10;
	localparam logic [4:0] FN_CALL1         = 5'h11;
	localparam logic [4:0] FN_BR0           = 5'h12;
	localparam logic [4:0] FN_BR1           = 5'h13;
	localparam logic [4:0] FN_CBR0          = 5'h14;
	localparam logic [4:0] FN_RET           = 5'h15;
	localparam logic [4:0] FN_LOG_SHIFT     = 5'h16;
	localparam logic [4:0] FN_CBR1          = 5'h19;
	localparam logic [4:0] FN_FLAG_LINK     = 5'h1a;
	localparam logic [4:0] FN_FLAG_SET      = 5'h1c;
	localparam logic [4:0] FN_OVF_SET       = 5'h1e;
	localparam logic [4:0] FN_IOR           = 5'h1f;

	// store field codes
	localparam logic [3:0] ST_F   = 4'h9;
	localparam logic [3:0] ST_Q   = 4'ha;
	localparam logic [3:0] ST_AAB = 4'hc;
	localparam logic [3:0] ST_B   = 4'hd;
	localparam logic [3:0] ST_A   = 4'he;
	localparam logic [3:0] ST_NOP = 4'hf;

	// special field shift codes
	localparam logic [3:0] SP_LEFT_ONE  = 4'h1;
	localparam logic [3:0] SP_RIGHT_ONE = 4'h2;

	// function generator control {mode, cin, sel0..sel3}
	localparam logic [5:0] FG_ADD  = 6'h19;
	localparam logic [5:0] FG_INC  = 6'h09;
	localparam logic [5:0] FG_IOR  = 6'h37;
	localparam logic [5:0] FG_NOR  = 6'h38;
	localparam logic [5:0] FG_SUB2 = 6'h06;
	localparam logic [5:0] FG_XOR  = 6'h36;
	localparam logic [5:0] FG_NOP  = 6'h00;

	// operating phase codes
	localparam logic [1:0] PH_FETCH = 2'h0;
	localparam logic [1:0] PH_1A    = 2'h1;

	// register port indexes
	localparam logic [3:0] RG_CTRL   = 4'h0;
	localparam logic [3:0] RG_STATUS = 4'h1;
	localparam logic [3:0] RG_CSAR   = 4'h2;
	localparam logic [3:0] RG_ACC_A  = 4'h3;
	localparam logic [3:0] RG_ACC_B  = 4'h4;
	localparam logic [3:0] RG_F      = 4'h5;
	localparam logic [3:0] RG_Q      = 4'h6;
	localparam logic [3:0] RG_SAVE   = 4'h7;

	// reset values
	localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
	localparam logic [CSAR_W-1:0] CSAR_RST = 10'h000;
	localparam logic [2:0]        CTRL_RST = 3'h0;

	typedef enum logic {SQ_RUN, SQ_BR_NOP} mfd_seq_e;
endpackage

/* File: rtl/mfd_decoder.sv */
// microword function field and store field decoder with its flags and shifter
//
// Notes on behaviour
// - sixteen divide steps leave quotient Q, remainder F
// - increment code puts R plus S plus one
// - add-one keeps overflow, extend for memory reference
// - inclusive OR code outputs R or S
// - branch suppresses skip, special, program counter read
// - target from microword bits 0-7, 17, 12
// - call branches, sets call flop, saves return
// - branch-type codes take two cycles, second idle
// - logical 32-bit shift, direction from special field
// - left flag link: flag in, top bit out
// - right flag link: flag to bit 15
// - multiply step adds when A bit 0 set
// - multiply shifts result right, carry into top; A right, result bit 0 into its top
// - NOR code outputs complement of R or S
// - phase code sets phase 1A, clears current
// - rotate flag with extend, or with index mode
// - return loads saved address, clears call flop
// - set flag and set overflow codes
// - subtract and exclusive OR codes
// - store code taken from microword bits 8-11
// - store code A loads the A register
// - addressed store picks A or B, else none
// - function generator control settings per function
`timescale 1ns/100ps
module mfd_decoder #(
	parameter int DIV_STEPS = mfd_pkg::DIV_STEPS_DEF
) (
	input  wire logic                        mclk,
	input  wire logic                        srst,
	input  wire logic [mfd_pkg::MW_W-1:0]    rom_instr_reg,
	input  wire logic [mfd_pkg::DATA_W-1:0]  r_bus,
	input  wire logic [mfd_pkg::DATA_W-1:0]  s_bus,
	input  wire logic                        halt_or_irq,
	input  wire logic [3:0]                  reg_addr,
	input  wire logic [mfd_pkg::DATA_W-1:0]  reg_wdata,
	input  wire logic                        reg_wr,
	input  wire logic                        reg_rd,
	output logic      [mfd_pkg::DATA_W-1:0]  reg_rdata,
	output logic      [mfd_pkg::DATA_W-1:0]  t_bus,
	output logic      [mfd_pkg::CSAR_W-1:0]  csar,
	output logic                             fg_mode,
	output logic                             fg_cin,
	output logic      [3:0]                  fg_sel,
	output logic                             overflow_update_en,
	output logic                             mult_add_select,
	output logic                             fn_carry_out,
	output logic                             fn_out_bit0,
	output logic                             branch_fetch_n,
	output logic                             skip_decode_en,
	output logic                             special_decode_en,
	output logic                             pc_read_low,
	output logic                             pc_read_bit9,
	output logic                             pc_read_high,
	output logic                             acc_a_load,
	output logic                             acc_b_load,
	output logic      [15:0]                 store_sel,
	output logic                             cpu_flag,
	output logic                             overflow
);
	if (DIV_STEPS < 1 || DIV_STEPS > 31)
	begin : g_bad_steps
		$error("DIV_STEPS must be 1 to 31");
	end

	mfd_pkg::mfd_seq_e            seq_q, seq_d;
	logic [mfd_pkg::DATA_W-1:0]   a_q, a_d, b_q, b_d, f_q, f_d, q_q, q_d;
	logic [mfd_pkg::DATA_W-1:0]   t_q, rdata_q;
	logic [mfd_pkg::CSAR_W-1:0]   csar_q, csar_d, save_q, save_d;
	logic                         flag_q, flag_d, ovf_q, ovf_d, ext_q, ext_d, idx_q, idx_d;
	logic                         call_q, call_d;
	logic [1:0]                   phase_q, phase_d;
	logic [4:0]                   div_cnt_q, div_cnt_d;
	logic [2:0]                   ctrl_q;

	// decode
	wire        run      = (seq_q == mfd_pkg::SQ_RUN);
	wire [4:0]  fn       = rom_instr_reg[mfd_pkg::FN_LSB +: 5];
	wire [3:0]  st       = rom_instr_reg[mfd_pkg::ST_LSB +: 4];
	wire [3:0]  sp       = rom_instr_reg[mfd_pkg::SP_LSB +: 4];
	wire        memref   = ctrl_q[0];
	wire        addr_a   = ctrl_q[1];
	wire        addr_b   = ctrl_q[2];
	wire        left     = (sp == mfd_pkg::SP_LEFT_ONE);
	wire        right    = (sp == mfd_pkg::SP_RIGHT_ONE);

	wire is_br   = run && (fn == mfd_pkg::FN_BR0 || fn == mfd_pkg::FN_BR1);
	wire is_call = run && (fn == mfd_pkg::FN_CALL0 || fn == mfd_pkg::FN_CALL1);
	wire is_cbr  = run && (fn == mfd_pkg::FN_CBR0 || fn == mfd_pkg::FN_CBR1);
	wire is_ret  = run && (fn == mfd_pkg::FN_RET);
	wire is_lgs  = run && (fn == mfd_pkg::FN_LOG_SHIFT);
	wire is_lwf  = run && (fn == mfd_pkg::FN_FLAG_LINK);
	wire is_mpy  = run && (fn == mfd_pkg::FN_MULT_STEP);
	wire is_div  = run && (fn == mfd_pkg::FN_DIV_STEP);
	wire is_p1a  = run && (fn == mfd_pkg::FN_PHASE_1A);
	wire is_rfe  = run && (fn == mfd_pkg::FN_ROT_FLAG_EXT);
	wire is_rfi  = run && (fn == mfd_pkg::FN_ROT_FLAG_IDX);
	wire is_cpu_flag_set_op = run && (fn == mfd_pkg::FN_FLAG_SET);
	wire is_sov  = run && (fn == mfd_pkg::FN_OVF_SET);
	wire is_sub  = run && (fn == mfd_pkg::FN_SUB);
	wire is_xor  = run && (fn == mfd_pkg::FN_XOR);
	wire is_nor  = run && (fn == mfd_pkg::FN_NOR);
	wire is_inc  = run && (fn == mfd_pkg::FN_INC);
	wire is_add_one_keep_ovf_op = run && (fn == mfd_pkg::FN_ADD_ONE_OVF);
	wire is_ior  = run && (fn == mfd_pkg::FN_IOR);

	// conditional branch only redirects during halt or interrupt
	wire jump      = is_br | is_call | (is_cbr & halt_or_irq);
	wire two_cycle = is_br | is_call | is_ret | is_cbr;
	wire br_fetch  = is_br | is_call | is_cbr;
	wire ior_en    = is_ior | two_cycle | is_lgs | is_lwf | is_cpu_flag_set_op | is_sov;
	wire [mfd_pkg::CSAR_W-1:0] target =
		{rom_instr_reg[mfd_pkg::TGT_B9], rom_instr_reg[mfd_pkg::TGT_B8],
		rom_instr_reg[7:0]};

	// function generator control word
	wire [5:0] fg_ctl =
		(is_inc | is_add_one_keep_ovf_op) ? mfd_pkg::FG_INC :
		ior_en ? mfd_pkg::FG_IOR :
		is_nor ? mfd_pkg::FG_NOR :
		is_xor ? mfd_pkg::FG_XOR :
		(is_sub | is_div) ? mfd_pkg::FG_SUB2 :
		(is_mpy & a_q[0]) ? mfd_pkg::FG_ADD : mfd_pkg::FG_NOP;

	// function generator result, bit 16 is carry out
	wire [16:0] sum_rs  = {1'b0, r_bus} + {1'b0, s_bus};
	wire [16:0] sum_rs1 = sum_rs + 17'h0_0001;
	wire [15:0] diff_rs = r_bus - s_bus;
	wire [16:0] fres =
		(is_inc | is_add_one_keep_ovf_op) ? sum_rs1 :
		is_sub ? {1'b0, diff_rs} :
		is_xor ? {1'b0, r_bus ^ s_bus} :
		is_nor ? {1'b0, ~(r_bus | s_bus)} :
		ior_en ? {1'b0, r_bus | s_bus} :
		is_mpy ? (a_q[0] ? sum_rs : {1'b0, r_bus}) :
		{1'b0, r_bus};
	wire ovf_now = ~(r_bus[15] ^ s_bus[15]) & (fres[15] ^ r_bus[15]);

	// shifter onto the T-bus
	wire [15:0] tval =
		is_mpy ? {fres[16], fres[15:1]} :
		(is_lgs & right) ? {1'b0, fres[15:1]} :
		(is_lgs & left) ? {fres[14:0], q_q[15]} :
		(is_lwf & left) ? {fres[14:0], flag_q} :
		(is_lwf & right) ? {flag_q, fres[15:1]} :
		fres[15:0];

	// divide step works on F and Q directly against the S-bus divisor
	wire [16:0] div_diff = {1'b0, f_q} - {1'b0, s_bus};
	wire        div_pos  = ~div_diff[16];

	// store field; idle in the second cycle of a branch
	wire [15:0] st_hot = 16'h0001 << st;
	wire        st_aab = run && (st == mfd_pkg::ST_AAB);
	wire        ld_a   = (run && st == mfd_pkg::ST_A) | (st_aab & addr_a);
	wire        ld_b   = (run && st == mfd_pkg::ST_B) | (st_aab & ~addr_a & addr_b);
	wire        ld_f   = run && (st == mfd_pkg::ST_F);
	wire        ld_q   = run && (st == mfd_pkg::ST_Q);

	// next state
	assign seq_d = two_cycle ? mfd_pkg::SQ_BR_NOP : mfd_pkg::SQ_RUN;
	assign csar_d = jump ? target :
		is_ret ? save_q : csar_q + 10'h001;
	assign save_d = is_call ? csar_q + 10'h001 : save_q;
	assign call_d = is_call ? 1'b1 : is_ret ? 1'b0 : call_q;
	// store to A wins over the internal shift of A
	assign a_d = ld_a ? tval :
		(is_mpy | (is_lgs & right)) ? {fres[0], a_q[15:1]} : a_q;
	assign b_d = ld_b ? tval : b_q;
	assign f_d = is_div ? (div_pos ? {div_diff[14:0], q_q[15]} :
		{f_q[14:0], q_q[15]}) : ld_f ? tval : f_q;
	assign q_d = is_div ? {q_q[14:0], div_pos} : ld_q ? tval :
		(is_lgs & left) ? {q_q[14:0], 1'b0} : q_q;
	assign flag_d = is_cpu_flag_set_op ? 1'b1 :
		(is_lwf & left) ? fres[15] :
		(is_lwf & right) ? fres[0] :
		is_rfe ? ext_q : is_rfi ? idx_q : flag_q;
	assign ext_d = is_rfe ? flag_q :
		(is_add_one_keep_ovf_op & memref & fres[16]) ? 1'b1 : ext_q;
	assign idx_d = is_rfi ? flag_q : idx_q;
	assign ovf_d = (is_sov | (is_add_one_keep_ovf_op & ovf_now)) ? 1'b1 : ovf_q;
	assign phase_d = is_p1a ? mfd_pkg::PH_1A : phase_q;
	assign div_cnt_d = !run ? div_cnt_q : !is_div ? 5'h00 :
		(div_cnt_q == 5'(DIV_STEPS)) ? 5'h01 : div_cnt_q + 5'h01;

	// register port read selection
	wire [15:0] status_w = {3'h0, div_cnt_q, (div_cnt_q == 5'(DIV_STEPS)), phase_q,
		call_q, idx_q, ext_q, ovf_q, flag_q};
	wire [15:0] rd_mux =
		(reg_addr == mfd_pkg::RG_CTRL)   ? {13'h0000, ctrl_q} :
		(reg_addr == mfd_pkg::RG_STATUS) ? status_w :
		(reg_addr == mfd_pkg::RG_CSAR)   ? {6'h00, csar_q} :
		(reg_addr == mfd_pkg::RG_ACC_A)  ? a_q :
		(reg_addr == mfd_pkg::RG_ACC_B)  ? b_q :
		(reg_addr == mfd_pkg::RG_F)      ? f_q :
		(reg_addr == mfd_pkg::RG_Q)      ? q_q :
		(reg_addr == mfd_pkg::RG_SAVE)   ? {6'h00, save_q} : 16'h0000;

	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			seq_q     <= mfd_pkg::SQ_RUN;
			csar_q    <= mfd_pkg::CSAR_RST;
			save_q    <= mfd_pkg::CSAR_RST;
			call_q    <= 1'b0;
			a_q       <= mfd_pkg::DATA_RST;
			b_q       <= mfd_pkg::DATA_RST;
			f_q       <= mfd_pkg::DATA_RST;
			q_q       <= mfd_pkg::DATA_RST;
			t_q       <= mfd_pkg::DATA_RST;
			flag_q    <= 1'b0;
			ovf_q     <= 1'b0;
			ext_q     <= 1'b0;
			idx_q     <= 1'b0;
			phase_q   <= mfd_pkg::PH_FETCH;
			div_cnt_q <= 5'h00;
		end
		else
		begin
			seq_q     <= seq_d;
			csar_q    <= csar_d;
			save_q    <= save_d;
			call_q    <= call_d;
			a_q       <= a_d;
			b_q       <= b_d;
			f_q       <= f_d;
			q_q       <= q_d;
			t_q       <= tval;
			flag_q    <= flag_d;
			ovf_q     <= ovf_d;
			ext_q     <= ext_d;
			idx_q     <= idx_d;
			phase_q   <= phase_d;
			div_cnt_q <= div_cnt_d;
		end
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			ctrl_q  <= mfd_pkg::CTRL_RST;
			rdata_q <= mfd_pkg::DATA_RST;
		end
		else
		begin
			if (reg_wr && reg_addr == mfd_pkg::RG_CTRL)
				ctrl_q <= reg_wdata[2:0];
			rdata_q <= reg_rd ? rd_mux : 16'h0000;
		end
	end

	assign reg_rdata          = rdata_q;
	assign t_bus              = t_q;
	assign csar               = csar_q;
	assign fg_mode            = fg_ctl[5];
	assign fg_cin             = fg_ctl[4];
	assign fg_sel             = fg_ctl[3:0];
	assign overflow_update_en = is_add_one_keep_ovf_op;
	assign mult_add_select    = is_mpy & a_q[0];
	assign fn_carry_out       = fres[16];
	assign fn_out_bit0        = fres[0];
	assign branch_fetch_n     = ~br_fetch;
	assign skip_decode_en     = ~br_fetch;
	assign special_decode_en  = ~br_fetch;
	assign pc_read_low        = ~br_fetch;
	assign pc_read_bit9       = ~br_fetch;
	assign pc_read_high       = ~br_fetch;
	assign acc_a_load         = ld_a;
	assign acc_b_load         = ld_b;
	// nop store code selects nothing
	assign store_sel          = run ? (st_hot & 16'h7fff) : 16'h0000;
	assign cpu_flag           = flag_q;
	assign overflow           = ovf_q;

	// checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);

	sequence s_branch_cycle;
		run && two_cycle;
	endsequence
	sequence s_idle_then_run;
		!run && store_sel == 16'h0000 ##1 run;
	endsequence

	a_branch_target: assert property (is_br |=> csar_q == $past(target))
		else $error("branch target not loaded");
	a_two_cycle: assert property (s_branch_cycle |=> s_idle_then_run)
		else $error("branch did not idle one cycle");
	a_call_save: assert property (is_call |=> call_q && save_q == $past(csar_q) + 10'h001)
		else $error("call did not save return");
	a_return_load: assert property (is_ret |=> csar_q == $past(save_q) && !call_q)
		else $error("return did not restore address");
	a_branch_block: assert property (br_fetch |-> !pc_read_low && !skip_decode_en && fg_ctl == mfd_pkg::FG_IOR)
		else $error("branch left decodes enabled");
	a_inc_sum: assert property (is_inc |=> t_bus == $past(r_bus) + $past(s_bus) + 16'h0001)
		else $error("increment result wrong");
	a_ior_out: assert property (is_ior |=> t_bus == ($past(r_bus) | $past(s_bus)))
		else $error("inclusive or result wrong");
	a_nor_out: assert property (is_nor |=> t_bus == ~($past(r_bus) | $past(s_bus)))
		else $error("nor result wrong");
	a_store_a: assert property (run && st == mfd_pkg::ST_A |=> a_q == $past(tval))
		else $error("A store missed");
	a_aab_none: assert property (st_aab && !addr_a && !addr_b |-> !acc_a_load && !acc_b_load)
		else $error("addressed store with no target");
	a_flag_set: assert property (is_cpu_flag_set_op |=> cpu_flag ##0 $past(fg_ctl) == mfd_pkg::FG_IOR)
		else $error("flag set failed");
	a_mpy_shift: assert property (is_mpy && !ld_a |=> a_q[15] == $past(fres[0]) && a_q[14:0] == $past(a_q[15:1]))
		else $error("multiply A shift wrong");
	a_div_count: assert property (div_cnt_q <= 5'(DIV_STEPS))
		else $error("divide count out of range");
	a_phase_set: assert property (is_p1a |=> phase_q == mfd_pkg::PH_1A)
		else $error("phase 1A not set");

endmodule // mfd_decoder

/* File: testbench/mfd_rom_model.sv */
// control store model for the microword decoder
`timescale 1ns/100ps
module mfd_rom_model #(
	parameter int DEPTH = 1024
) (
	input  wire logic [mfd_pkg::CSAR_W-1:0] csar,
	output logic      [mfd_pkg::MW_W-1:0]   word
);
	logic [mfd_pkg::MW_W-1:0] mem [DEPTH];

	// combinational read: the idle cycle already sees the new address
	assign word = mem[csar];
endmodule // mfd_rom_model

/* File: testbench/testbench.sv */
// self-checking bench for the microword function and store decoder
`timescale 1ns/100ps
module testbench;
	typedef struct {string nm; logic [15:0] ex; bit tb;} mfd_note_s;
	logic        mclk, srst, reg_wr, reg_rd, halt_or_irq, use_rom, tchk, rd_d, tc_d;
	logic [23:0] mw, rom_w, instr;
	logic [15:0] r, s, bval, reg_wdata, reg_rdata, t_bus, store_sel;
	logic [9:0]  csar;
	logic [3:0]  reg_addr, fg_sel;
	logic        fg_mode, fg_cin, ovf_en, fco, fob0, bfn, sde, spde, prl, pr9, prh;
	logic        a_ld, b_ld, cflag, ovf, mas;
	int          mismatches, check_count, cyc, i, j, seed_v;
	logic [15:0] rv, sv, av, ov, ov2, qq, fq, dv;
	logic [16:0] sum17;
	mfd_note_s   notes[$];
	mfd_note_s   nt;
	logic [9:0]  csar_exp [7] = '{10'h001, 10'h335, 10'h336, 10'h002, 10'h003, 10'h0a7, 10'h0a8};
	logic [4:0]  op_fn [7];

	assign instr = use_rom ? rom_w : mw;

	mfd_rom_model u_rom (.csar(csar), .word(rom_w));

	mfd_decoder u_dut (.mclk(mclk), .srst(srst), .rom_instr_reg(instr), .r_bus(r), .s_bus(s),
		.halt_or_irq(halt_or_irq), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .t_bus(t_bus), .csar(csar), .fg_mode(fg_mode),
		.fg_cin(fg_cin), .fg_sel(fg_sel), .overflow_update_en(ovf_en), .mult_add_select(mas),
		.fn_carry_out(fco), .fn_out_bit0(fob0), .branch_fetch_n(bfn), .skip_decode_en(sde),
		.special_decode_en(spde), .pc_read_low(prl), .pc_read_bit9(pr9), .pc_read_high(prh),
		.acc_a_load(a_ld), .acc_b_load(b_ld), .store_sel(store_sel), .cpu_flag(cflag),
		.overflow(ovf));

	function automatic logic [23:0] mw_of(input logic [4:0] fn, input logic [3:0] st,
		input logic b17, input logic [7:0] lo);
		return {6'h00, b17, fn, st, lo};
	endfunction

	function automatic logic [15:0] alu_exp(input logic [4:0] fn, input logic [15:0] a,
		input logic [15:0] b);
		case (fn)
			mfd_pkg::FN_INC, mfd_pkg::FN_ADD_ONE_OVF: return a + b + 16'h0001;
			mfd_pkg::FN_IOR: return a | b;
			mfd_pkg::FN_NOR: return ~(a | b);
			mfd_pkg::FN_SUB: return a - b;
			default: return a ^ b;
		endcase
	endfunction

	task automatic close_out();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] sn);
		check_count++;
		if (sn !== ex)
		begin
			mismatches++;
			$display("BAD %s expected %h seen %h", nm, ex, sn);
		end
	endtask

	task automatic note(input string nm, input logic [15:0] ex, input bit tb);
		notes.push_back(mfd_note_s'{nm, ex, tb});
	endtask

	// one microword per call, operands move with it
	task automatic step(input logic [23:0] w, input logic [15:0] rv_i, input logic [15:0] sv_i,
		input logic [15:0] ex, input bit tc);
		@(posedge mclk);
		use_rom <= 1'b0;
		mw <= w;
		r <= rv_i;
		s <= sv_i;
		tchk <= tc;
		if (tc)
			note("t_bus", ex, 1'b1);
		#1;
	endtask

	task automatic rd_reg(input logic [3:0] a, input logic [15:0] ex, input string nm);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		note(nm, ex, 1'b0);
		@(posedge mclk);
		reg_rd <= 1'b0;
	endtask

	task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask

	initial
	begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	// results arrive one cycle after their cause, oldest note first
	always @(posedge mclk)
	begin
		rd_d <= reg_rd;
		tc_d <= tchk;
		cyc <= cyc + 1;
		if (cyc > 3000)
		begin
			mismatches++;
			close_out();
		end
	end

	always @(negedge mclk)
		if ((rd_d || tc_d) && notes.size() > 0)
		begin
			nt = notes.pop_front();
			chk(nt.nm, nt.ex, nt.tb ? t_bus : reg_rdata);
		end

	initial
	begin
		srst = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		halt_or_irq = 1'b0;
		use_rom = 1'b1;
		tchk = 1'b0;
		rd_d = 1'b0;
		tc_d = 1'b0;
		cyc = 0;
		reg_addr = mfd_pkg::RG_STATUS;
		reg_wdata = 16'h0000;
		r = 16'h0000;
		s = 16'h0000;
		mw = mw_of(mfd_pkg::FN_IOR, mfd_pkg::ST_NOP, 1'b0, 8'h00);
		op_fn = '{mfd_pkg::FN_INC, mfd_pkg::FN_ADD_ONE_OVF, mfd_pkg::FN_IOR, mfd_pkg::FN_NOR,
			mfd_pkg::FN_SUB, mfd_pkg::FN_XOR, mfd_pkg::FN_NOR};
		for (i = 0; i < 1024; i++)
			u_rom.mem[i] = mw;
		u_rom.mem[1] = mw_of(mfd_pkg::FN_CALL1, mfd_pkg::ST_NOP, 1'b1, 8'h35);
		u_rom.mem[10'h335] = mw_of(mfd_pkg::FN_IOR, mfd_pkg::ST_A, 1'b0, 8'h00);
		u_rom.mem[10'h336] = mw_of(mfd_pkg::FN_RET, mfd_pkg::ST_NOP, 1'b0, 8'h00);
		u_rom.mem[3] = mw_of(mfd_pkg::FN_BR0, mfd_pkg::ST_NOP, 1'b0, 8'ha7);
		seed_v = $urandom(24984);
		repeat (5) @(posedge mclk);
		srst <= 1'b0;
		// call, return and branch run from the control store model
		for (i = 0; i < 7; i++)
		begin
			@(posedge mclk);
			reg_rd <= (i == 1 || i == 4);
			if (i == 1)
				note("call flop", 16'h0010, 1'b0);
			if (i == 4)
				note("call flop", 16'h0000, 1'b0);
			#1;
			chk("csar", {6'h00, csar_exp[i]}, {6'h00, csar});
			if (i == 0)
				chk("branch fetch", 16'h0000, {15'h0000, bfn});
			if (i == 1)
				chk("idle store", 16'h0000, store_sel);
			if (i == 4)
				chk("branch gating", 16'h0000, {11'h000, sde, spde, prl, pr9, prh});
		end
		for (i = 0; i < 7; i++)
		begin
			rv = (i == 6) ? 16'h0000 : 16'($urandom);
			sv = (i == 6) ? 16'h0000 : 16'($urandom);
			step(mw_of(op_fn[i], mfd_pkg::ST_NOP, 1'b0, 8'h00), rv, sv,
				alu_exp(op_fn[i], rv, sv), 1'b1);
			chk("ovf enable", {15'h0000, op_fn[i] == mfd_pkg::FN_ADD_ONE_OVF},
				{15'h0000, ovf_en});
			chk("fg mode cin", (op_fn[i] inside {mfd_pkg::FN_INC, mfd_pkg::FN_ADD_ONE_OVF,
				mfd_pkg::FN_SUB}) ? 16'h0000 : 16'h0003, {14'h0000, fg_mode, fg_cin});
		end
		rv = 16'($urandom);
		sv = 16'($urandom) | 16'h0001;
		av = rv | sv;
		step(mw_of(mfd_pkg::FN_IOR, mfd_pkg::ST_A, 1'b0, 8'h00), rv, sv, 16'h0000, 1'b0);
		chk("store select", 16'h4000, store_sel);
		chk("a load", 16'h0001, {15'h0000, a_ld});
		rd_reg(mfd_pkg::RG_ACC_A, av, "acc a");
		// A is odd here, so the multiply step must add
		rv = 16'($urandom);
		sv = 16'($urandom);
		sum17 = {1'b0, rv} + {1'b0, sv};
		step(mw_of(mfd_pkg::FN_MULT_STEP, mfd_pkg::ST_B, 1'b0, 8'h20), rv, sv,
			sum17[16:1], 1'b1);
		chk("mult add", 16'h0001, {15'h0000, mas});
		step(mw_of(mfd_pkg::FN_IOR, mfd_pkg::ST_NOP, 1'b0, 8'h00), rv, sv, 16'h0000, 1'b0);
		rd_reg(mfd_pkg::RG_ACC_A, {sum17[0], av[15:1]}, "mpy a");
		wr_reg(mfd_pkg::RG_CTRL, 16'h0004);
		rv = 16'($urandom);
		sv = 16'($urandom);
		bval = rv | sv;
		step(mw_of(mfd_pkg::FN_IOR, mfd_pkg::ST_AAB, 1'b0, 8'h00), rv, sv, 16'h0000, 1'b0);
		chk("aab loads b", 16'h0001, {14'h0000, a_ld, b_ld});
		rd_reg(mfd_pkg::RG_ACC_B, bval, "acc b");
		wr_reg(mfd_pkg::RG_CTRL, 16'h0000);
		rv = 16'($urandom);
		sv = 16'($urandom);
		step(mw_of(mfd_pkg::FN_IOR, mfd_pkg::ST_AAB, 1'b0, 8'h00), rv, sv, 16'h0000, 1'b0);
		chk("aab no store", 16'h0000, {14'h0000, a_ld, b_ld});
		rd_reg(mfd_pkg::RG_ACC_B, bval, "acc b kept");
		rd_reg(4'hf, 16'h0000, "unmapped");
		step(mw_of(mfd_pkg::FN_FLAG_SET, mfd_pkg::ST_NOP, 1'b0, 8'h00), rv, sv, 16'h0000, 1'b0);
		step(mw_of(mfd_pkg::FN_OVF_SET, mfd_pkg::ST_NOP, 1'b0, 8'h00), rv, sv, 16'h0000, 1'b0);
		step(mw_of(mfd_pkg::FN_PHASE_1A, mfd_pkg::ST_NOP, 1'b0, 8'h00), rv, sv, 16'h0000, 1'b0);
		chk("flags set", 16'h0003, {14'h0000, cflag, ovf});
		step(mw_of(mfd_pkg::FN_IOR, mfd_pkg::ST_NOP, 1'b0, 8'h00), rv, sv, 16'h0000, 1'b0);
		rd_reg(mfd_pkg::RG_STATUS, 16'h0023, "status phase");
		// two flops rotating is a swap: flag goes to extend
		step(mw_of(mfd_pkg::FN_ROT_FLAG_EXT, mfd_pkg::ST_NOP, 1'b0, 8'h00), rv, sv,
			16'h0000, 1'b0);
		step(mw_of(mfd_pkg::FN_IOR, mfd_pkg::ST_NOP, 1'b0, 8'h00), rv, sv, 16'h0000, 1'b0);
		rd_reg(mfd_pkg::RG_STATUS, 16'h0026, "status rotate");
		// logical shifts: right pulls a zero in, left pulls Q bit 15 in
		rv = 16'($urandom);
		sv = 16'($urandom);
		qq = rv ^ sv;
		ov = rv | sv;
		step(mw_of(mfd_pkg::FN_IOR, mfd_pkg::ST_Q, 1'b0, 8'h00), qq, 16'h0000, 16'h0000, 1'b0);
		step(mw_of(mfd_pkg::FN_LOG_SHIFT, mfd_pkg::ST_NOP, 1'b0, 8'h20), rv, sv,
			{1'b0, ov[15:1]}, 1'b1);
		step(mw_of(mfd_pkg::FN_LOG_SHIFT, mfd_pkg::ST_NOP, 1'b0, 8'h10), rv, sv,
			{ov[14:0], qq[15]}, 1'b1);
		// flag is clear here; each link leaves its outgoing bit in the flag
		rv = 16'($urandom);
		sv = 16'($urandom);
		ov2 = rv | sv;
		step(mw_of(mfd_pkg::FN_FLAG_LINK, mfd_pkg::ST_NOP, 1'b0, 8'h10), rv, sv,
			{ov2[14:0], 1'b0}, 1'b1);
		rv = 16'($urandom);
		sv = 16'($urandom);
		ov = rv | sv;
		step(mw_of(mfd_pkg::FN_FLAG_LINK, mfd_pkg::ST_NOP, 1'b0, 8'h20), rv, sv,
			{ov2[15], ov[15:1]}, 1'b1);
		step(mw_of(mfd_pkg::FN_ROT_FLAG_IDX, mfd_pkg::ST_NOP, 1'b0, 8'h00), rv, sv,
			16'h0000, 1'b0);
		step(mw_of(mfd_pkg::FN_IOR, mfd_pkg::ST_NOP, 1'b0, 8'h00), rv, sv, 16'h0000, 1'b0);
		rd_reg(mfd_pkg::RG_STATUS, {12'h002, ov[0], 3'h6}, "status link");
		// conditional branch: taken under halt or interrupt, else idle only
		@(posedge mclk);
		halt_or_irq <= 1'b1;
		step(mw_of(mfd_pkg::FN_CBR1, mfd_pkg::ST_NOP, 1'b1, 8'h5c), rv, sv, 16'h0000, 1'b0);
		chk("cbr gating", 16'h0000, {10'h000, bfn, sde, spde, prl, pr9, prh});
		step(mw_of(mfd_pkg::FN_IOR, mfd_pkg::ST_NOP, 1'b0, 8'h00), rv, sv, 16'h0000, 1'b0);
		chk("cbr taken", 16'h035c, {6'h00, csar});
		@(posedge mclk);
		halt_or_irq <= 1'b0;
		step(mw_of(mfd_pkg::FN_CBR0, mfd_pkg::ST_NOP, 1'b0, 8'h5c), rv, sv, 16'h0000, 1'b0);
		step(mw_of(mfd_pkg::FN_IOR, mfd_pkg::ST_NOP, 1'b0, 8'h00), rv, sv, 16'h0000, 1'b0);
		chk("cbr not taken", 16'h035f, {6'h00, csar});
		// divide: remainder below a positive divisor keeps the loop in range
		dv = {1'b0, 15'($urandom)} | 16'h0001;
		fq = 16'($urandom) % dv;
		qq = 16'($urandom);
		step(mw_of(mfd_pkg::FN_IOR, mfd_pkg::ST_F, 1'b0, 8'h00), fq, 16'h0000, 16'h0000, 1'b0);
		step(mw_of(mfd_pkg::FN_IOR, mfd_pkg::ST_Q, 1'b0, 8'h00), qq, 16'h0000, 16'h0000, 1'b0);
		for (j = 0; j < mfd_pkg::DIV_STEPS_DEF; j++)
			step(mw_of(mfd_pkg::FN_DIV_STEP, mfd_pkg::ST_F, 1'b0, 8'h10), 16'h0000, dv,
				16'h0000, 1'b0);
		for (j = 0; j < mfd_pkg::DIV_STEPS_DEF; j++)
		begin
			ov = fq - dv;
			fq = ov[15] ? {fq[14:0], qq[15]} : {ov[14:0], qq[15]};
			qq = {qq[14:0], ~ov[15]};
		end
		step(mw_of(mfd_pkg::FN_IOR, mfd_pkg::ST_NOP, 1'b0, 8'h00), 16'h0000, 16'h0000,
			16'h0000, 1'b0);
		rd_reg(mfd_pkg::RG_F, fq, "remainder");
		rd_reg(mfd_pkg::RG_Q, qq, "quotient");
		repeat (3) @(posedge mclk);
		chk("notes left", 16'h0000, 16'(notes.size()));
		close_out();
	end
endmodule // testbench
